// File: design/tcpm_pkg.sv
package tcpm_pkg;

	// Register byte offsets.
	localparam logic [11:0] CFG_OFF = 12'h0000;
	localparam logic [11:0] MODE_OFF = 12'h0004;
	localparam logic [11:0] CTL_OFF = 12'h000C;
	localparam logic [11:0] IMR_OFF = 12'h0018;
	localparam logic [11:0] RIS_OFF = 12'h001C;
	localparam logic [11:0] MIS_OFF = 12'h0020;
	localparam logic [11:0] ICR_OFF = 12'h0024;
	localparam logic [11:0] ILR_OFF = 12'h0028;
	localparam logic [11:0] MATCH_OFF = 12'h0030;
	localparam logic [11:0] PRE_OFF = 12'h0038;
	localparam logic [11:0] CNT_OFF = 12'h0048;

	// Global configuration codes.
	localparam logic [2:0] CFG_32_TIMER = 3'h0;
	localparam logic [2:0] CFG_32_RTC = 3'h1;
	localparam logic [2:0] CFG_16_SPLIT = 3'h4;

	// Timer mode field codes.
	localparam logic [1:0] MODE_ONE_SHOT = 2'h1;
	localparam logic [1:0] MODE_PERIODIC = 2'h2;
	localparam logic [1:0] MODE_CAPTURE = 2'h3;

	// Mode register field positions.
	localparam int MODE_FIELD_LO = 0;
	localparam int CAPTURE_MODE_POS = 2;
	localparam int ALT_MODE_POS = 3;

	// Control register field positions.
	localparam int ENABLE_POS = 0;
	localparam int EVENT_LO = 2;
	localparam int PWM_INVERT_POS = 6;

	// Edge event select codes.
	localparam logic [1:0] EVENT_RISE = 2'h0;
	localparam logic [1:0] EVENT_FALL = 2'h1;
	localparam logic [1:0] EVENT_BOTH = 2'h3;

	// Status bit positions shared by mask, raw, masked and clear registers.
	localparam int TIMEOUT_POS = 0;
	localparam int COUNT_MATCH_POS = 1;
	localparam int EDGE_EVENT_POS = 2;
	localparam int RTC_POS = 3;

	// Reset values, the clock-mode start value and shared constants.
	localparam logic [31:0] ILR_RESET = 32'h0000_FFFF;
	localparam logic [31:0] MATCH_RESET = 32'h0000_FFFF;
	localparam logic [31:0] RTC_START = 32'h0000_0001;
	localparam logic [31:0] ZERO32 = 32'h0000_0000;
	localparam logic [15:0] ZERO16 = 16'h0000;
	localparam logic [7:0] ZERO8 = 8'h00;
	localparam logic [31:0] ONE32 = 32'h0000_0001;
	localparam logic [15:0] ONE16 = 16'h0001;
	localparam logic [7:0] ONE8 = 8'h01;

	// Slow reference clock is divided down to one tick per second.
	localparam int RTC_DIV_DEFAULT = 32768;

endpackage : tcpm_pkg

// File: design/tcpm_edge_sync.sv
// Brings the capture pin into the clock domain and reports its edges.
module tcpm_edge_sync
(
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic pin_in,
	output logic rise_out,
	output logic fall_out
);

	logic s1_q;
	logic s2_q;
	logic s3_q;
	logic level_q;

	// Three-stage synchroniser; only the second stage reads the first.
	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in)
		begin
			s1_q <= 1'b0;
			s2_q <= 1'b0;
			s3_q <= 1'b0;
		end
		else
		begin
			s1_q <= pin_in;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// A new level counts once the second and third stages agree.
	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in)
			level_q <= 1'b0;
		else if (s2_q == s3_q)
			level_q <= s3_q;
	end

	// Edges come from comparing the accepted level with the agreed new sample.
	assign rise_out = (s2_q == s3_q) && s3_q && !level_q;
	assign fall_out = (s2_q == s3_q) && !s3_q && level_q;

endmodule // tcpm_edge_sync

// File: design/tcpm_timer.sv
// Decided for this implementation: the register addresses and the plain strobed port.
module tcpm_timer
#(
	parameter int RTC_DIV = tcpm_pkg::RTC_DIV_DEFAULT
)
(
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic [11:0] addr_in,
	input wire logic [31:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	output logic [31:0] rdata_out,
	input wire logic ccp_in,
	output logic pwm_out
);

	typedef enum logic [5:0]
	{
		ST_TIMER32 = 6'b00_0001,
		ST_RTC = 6'b00_0010,
		ST_TIMER16 = 6'b00_0100,
		ST_EDGE_COUNT = 6'b00_1000,
		ST_EDGE_TIME = 6'b01_0000,
		ST_PWM = 6'b10_0000
	} tcpm_mode_type;

	logic [2:0] cfg_q;
	logic [3:0] mode_q;
	logic [6:0] ctl_q;
	logic [3:0] imr_q;
	logic [3:0] ris_q;
	logic [31:0] ilr_q;
	logic [31:0] match_q;
	logic [7:0] pre_q;
	logic [7:0] pre_cnt_q;
	logic [31:0] cnt_q;
	logic [15:0] cap_q;
	logic [31:0] rdata_q;
	logic [31:0] rtc_div_q;
	logic pwm_q;
	logic rise;
	logic fall;
	logic edge_hit;
	logic rtc_tick;
	logic enable;
	logic [1:0] mode_field;
	logic [1:0] event_sel;
	logic [3:0] ris_set;
	logic wr_cfg;
	logic wr_ctl;
	logic wr_ilr;
	tcpm_mode_type op;

	// Decrements a 16-bit count, wrapping through zero.
	function automatic logic [15:0] dec16(input logic [15:0] v);
		return v - tcpm_pkg::ONE16;
	endfunction

	// Tells whether a write strobe targets a given offset.
	function automatic logic hit(input logic [11:0] off);
		return wr_in && (addr_in == off);
	endfunction

	tcpm_edge_sync u_sync
	(
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.pin_in(ccp_in),
		.rise_out(rise),
		.fall_out(fall)
	);

	assign wr_cfg = hit(tcpm_pkg::CFG_OFF);
	assign wr_ctl = hit(tcpm_pkg::CTL_OFF);
	assign wr_ilr = hit(tcpm_pkg::ILR_OFF);
	assign enable = ctl_q[tcpm_pkg::ENABLE_POS];
	assign mode_field = mode_q[tcpm_pkg::MODE_FIELD_LO +: 2];
	assign event_sel = ctl_q[tcpm_pkg::EVENT_LO +: 2];

	// Decodes the operating mode from configuration and mode registers.
	always_comb
	begin
		if (cfg_q == tcpm_pkg::CFG_32_RTC)
			op = ST_RTC;
		else if (cfg_q != tcpm_pkg::CFG_16_SPLIT)
			op = ST_TIMER32;
		else if (mode_q[tcpm_pkg::ALT_MODE_POS] && mode_field == tcpm_pkg::MODE_PERIODIC)
			op = ST_PWM;
		else if (mode_field == tcpm_pkg::MODE_CAPTURE && mode_q[tcpm_pkg::CAPTURE_MODE_POS])
			op = ST_EDGE_TIME;
		else if (mode_field == tcpm_pkg::MODE_CAPTURE)
			op = ST_EDGE_COUNT;
		else
			op = ST_TIMER16;
	end

	// Qualifies pin edges by the event select; timing mode never takes both edges.
	always_comb
	begin
		unique case (event_sel)
			tcpm_pkg::EVENT_RISE: edge_hit = rise;
			tcpm_pkg::EVENT_FALL: edge_hit = fall;
			tcpm_pkg::EVENT_BOTH: edge_hit = (op == ST_EDGE_TIME) ? rise : (rise || fall);
			default: edge_hit = 1'b0;
		endcase
	end

	// Divides the slow reference on the pin down to one tick per second.
	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in)
			rtc_div_q <= tcpm_pkg::ZERO32;
		else if (op != ST_RTC || !enable)
			rtc_div_q <= tcpm_pkg::ZERO32;
		else if (rise)
			rtc_div_q <= (rtc_div_q == 32'(RTC_DIV - 1)) ? tcpm_pkg::ZERO32 : rtc_div_q + tcpm_pkg::ONE32;
	end
	assign rtc_tick = rise && (rtc_div_q == 32'(RTC_DIV - 1));

	// Software-written configuration, mode, mask, load, match and prescale registers.
	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in)
		begin
			cfg_q <= tcpm_pkg::CFG_32_TIMER;
			mode_q <= 4'h0;
			imr_q <= 4'h0;
			ilr_q <= tcpm_pkg::ILR_RESET;
			match_q <= tcpm_pkg::MATCH_RESET;
			pre_q <= tcpm_pkg::ZERO8;
		end
		else if (wr_in)
		begin
			unique case (addr_in)
				tcpm_pkg::CFG_OFF: cfg_q <= wdata_in[2:0];
				tcpm_pkg::MODE_OFF: mode_q <= wdata_in[3:0];
				tcpm_pkg::IMR_OFF: imr_q <= wdata_in[3:0];
				tcpm_pkg::ILR_OFF: ilr_q <= wdata_in;
				tcpm_pkg::MATCH_OFF: match_q <= wdata_in;
				tcpm_pkg::PRE_OFF: pre_q <= wdata_in[7:0];
				default: ;
			endcase
		end
	end

	// Control register; hardware clears enable on a one-shot timeout or a count match.
	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in)
			ctl_q <= 7'h00;
		else if (wr_ctl)
			ctl_q <= wdata_in[6:0];
		else if (ris_set[tcpm_pkg::COUNT_MATCH_POS])
			ctl_q[tcpm_pkg::ENABLE_POS] <= 1'b0;
		else if (ris_set[tcpm_pkg::TIMEOUT_POS] && mode_field == tcpm_pkg::MODE_ONE_SHOT)
			ctl_q[tcpm_pkg::ENABLE_POS] <= 1'b0;
	end

	// Works out which status events this cycle raises.
	always_comb
	begin
		ris_set = 4'h0;
		if (enable)
		begin
			unique case (op)
				ST_TIMER32: ris_set[tcpm_pkg::TIMEOUT_POS] = (cnt_q == tcpm_pkg::ZERO32);
				ST_TIMER16: ris_set[tcpm_pkg::TIMEOUT_POS] = (cnt_q[15:0] == tcpm_pkg::ZERO16) && (pre_cnt_q == tcpm_pkg::ZERO8);
				ST_RTC: ris_set[tcpm_pkg::RTC_POS] = rtc_tick && (cnt_q == match_q);
				ST_EDGE_COUNT: ris_set[tcpm_pkg::COUNT_MATCH_POS] = edge_hit && (dec16(cnt_q[15:0]) == match_q[15:0]);
				ST_EDGE_TIME: ris_set[tcpm_pkg::EDGE_EVENT_POS] = edge_hit;
				ST_PWM: ris_set = 4'h0;
			endcase
		end
	end

	// Raw status: a set in the same cycle as a clear wins.
	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in)
			ris_q <= 4'h0;
		else if (hit(tcpm_pkg::ICR_OFF))
			ris_q <= (ris_q & ~wdata_in[3:0]) | ris_set;
		else
			ris_q <= ris_q | ris_set;
	end

	// Prescale counter extends only the 16-bit one-shot and periodic modes.
	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in)
			pre_cnt_q <= tcpm_pkg::ZERO8;
		else if (op != ST_TIMER16 || !enable || pre_cnt_q == tcpm_pkg::ZERO8)
			pre_cnt_q <= (op == ST_TIMER16 && enable) ? pre_q : tcpm_pkg::ZERO8;
		else
			pre_cnt_q <= pre_cnt_q - tcpm_pkg::ONE8;
	end

	// Main counter; a load write takes effect on the next cycle, except in clock and edge-count modes.
	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in)
			cnt_q <= tcpm_pkg::ILR_RESET;
		else if (wr_cfg && wdata_in[2:0] == tcpm_pkg::CFG_32_RTC)
			cnt_q <= tcpm_pkg::RTC_START;
		else if (wr_ilr && op != ST_RTC && op != ST_EDGE_COUNT)
			cnt_q <= wdata_in;
		else if (enable)
		begin
			unique case (op)
				ST_TIMER32:
					cnt_q <= (cnt_q == tcpm_pkg::ZERO32) ? ilr_q : cnt_q - tcpm_pkg::ONE32;
				ST_TIMER16:
					if (pre_cnt_q == tcpm_pkg::ZERO8)
						cnt_q <= (cnt_q[15:0] == tcpm_pkg::ZERO16) ? {16'h0000, ilr_q[15:0]} : {16'h0000, dec16(cnt_q[15:0])};
				ST_RTC:
					if (rtc_tick)
						cnt_q <= (cnt_q == match_q) ? tcpm_pkg::ZERO32 : cnt_q + tcpm_pkg::ONE32;
				ST_EDGE_COUNT:
					if (ris_set[tcpm_pkg::COUNT_MATCH_POS])
						cnt_q <= {16'h0000, ilr_q[15:0]};
					else if (edge_hit)
						cnt_q <= {16'h0000, dec16(cnt_q[15:0])};
				ST_EDGE_TIME, ST_PWM:
					cnt_q <= (cnt_q[15:0] == tcpm_pkg::ZERO16) ? {16'h0000, ilr_q[15:0]} : {16'h0000, dec16(cnt_q[15:0])};
			endcase
		end
	end

	// Captured count holds until the next selected edge.
	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in)
			cap_q <= tcpm_pkg::ILR_RESET[15:0];
		else if (ris_set[tcpm_pkg::EDGE_EVENT_POS])
			cap_q <= cnt_q[15:0];
	end

	// PWM level rises at the start value and falls at the match value.
	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in)
			pwm_q <= 1'b0;
		else if (op != ST_PWM || !enable)
			pwm_q <= 1'b0;
		else if (cnt_q[15:0] == ilr_q[15:0])
			pwm_q <= 1'b1;
		else if (cnt_q[15:0] == match_q[15:0])
			pwm_q <= 1'b0;
	end
	assign pwm_out = pwm_q ^ ctl_q[tcpm_pkg::PWM_INVERT_POS];

	// Read data stands in the cycle after the read strobe only.
	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in || !rd_in)
			rdata_q <= tcpm_pkg::ZERO32;
		else
		begin
			unique case (addr_in)
				tcpm_pkg::CFG_OFF: rdata_q <= {29'h0000_0000, cfg_q};
				tcpm_pkg::MODE_OFF: rdata_q <= {28'h000_0000, mode_q};
				tcpm_pkg::CTL_OFF: rdata_q <= {25'h000_0000, ctl_q};
				tcpm_pkg::IMR_OFF: rdata_q <= {28'h000_0000, imr_q};
				tcpm_pkg::RIS_OFF: rdata_q <= {28'h000_0000, ris_q};
				tcpm_pkg::MIS_OFF: rdata_q <= {28'h000_0000, ris_q & imr_q};
				tcpm_pkg::ILR_OFF: rdata_q <= ilr_q;
				tcpm_pkg::MATCH_OFF: rdata_q <= match_q;
				tcpm_pkg::PRE_OFF: rdata_q <= {24'h00_0000, pre_q};
				tcpm_pkg::CNT_OFF: rdata_q <= (op == ST_EDGE_TIME) ? {16'h0000, cap_q} : cnt_q;
				default: rdata_q <= tcpm_pkg::ZERO32;
			endcase
		end
	end
	assign rdata_out = rdata_q;

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);

	// Edge counting stops and reloads after the match.
	count_stop_a: assert property ((op == ST_EDGE_COUNT && ris_set[1] && !wr_in) |=> !enable && cnt_q[15:0] == ilr_q[15:0])
		else $error("count match did not stop and reload");
	// No edge moves a disabled edge counter.
	edge_ignore_a: assert property ((op == ST_EDGE_COUNT && !enable && !wr_in) |=> $stable(cnt_q))
		else $error("disabled edge counter moved");
	// Each qualifying edge that does not hit the match takes exactly one off the count.
	edge_decr_a: assert property ((op == ST_EDGE_COUNT && enable && edge_hit && !ris_set[1] && !wr_in) |=> cnt_q[15:0] == $past(cnt_q[15:0]) - 16'h0001)
		else $error("edge did not decrement by one");
	// Capture register takes the count of the selected edge.
	capture_value_a: assert property ((op == ST_EDGE_TIME && enable && edge_hit) |=> cap_q == $past(cnt_q[15:0]) && ris_q[2])
		else $error("capture value or flag wrong");
	// Timing mode reloads from the load value at zero.
	time_reload_a: assert property ((op == ST_EDGE_TIME && enable && cnt_q[15:0] == 16'h0000 && !wr_in) |=> cnt_q[15:0] == ilr_q[15:0])
		else $error("timing counter did not reload");
	// PWM mode leaves status untouched.
	pwm_quiet_a: assert property ((op == ST_PWM && !wr_in) |=> $stable(ris_q))
		else $error("status changed in pwm mode");
	// PWM level rises at the start value, with invert applied.
	pwm_level_a: assert property ((op == ST_PWM && enable && cnt_q[15:0] == ilr_q[15:0] && !wr_in) |=> pwm_out == !ctl_q[6])
		else $error("pwm did not assert at start value");
	// A set flag survives a simultaneous clear.
	set_wins_a: assert property ((ris_set[0] && hit(tcpm_pkg::ICR_OFF)) |=> ris_q[0])
		else $error("timeout flag lost to clear");
	// One-shot stops after timeout, periodic keeps running.
	oneshot_stop_a: assert property ((op == ST_TIMER32 && ris_set[0] && !wr_in) |=> enable == ($past(mode_field) != 2'h1))
		else $error("timeout enable behaviour wrong");
	// Clock mode rolls to zero on match.
	rtc_roll_a: assert property ((op == ST_RTC && ris_set[3] && !wr_in) |=> cnt_q == 32'h0000_0000)
		else $error("rtc did not roll over");

	// Edge and PWM modes never run the prescaler.
	no_prescale_a: assert property ((op == ST_EDGE_COUNT || op == ST_EDGE_TIME || op == ST_PWM) |=> pre_cnt_q == tcpm_pkg::ZERO8)
		else $error("prescaler ran outside timer modes");

	// Main scenarios that the tests are meant to reach.
	cover_count_c: cover property (op == ST_EDGE_COUNT && ris_set[1]);
	cover_capture_c: cover property (op == ST_EDGE_TIME && ris_set[2]);
	cover_pwm_c: cover property (op == ST_PWM && $rose(pwm_q) ##[1:200] $fell(pwm_q));
	cover_rtc_c: cover property (op == ST_RTC && ris_set[tcpm_pkg::RTC_POS]);
	cover_oneshot_c: cover property (op == ST_TIMER16 && ris_set[tcpm_pkg::TIMEOUT_POS] && mode_field == tcpm_pkg::MODE_ONE_SHOT);

endmodule // tcpm_timer

// File: tb/tcpm_pin_model.sv
// Drives the capture pin with a burst of level changes on request.
module tcpm_pin_model
(
	input wire logic clk_in,
	input wire logic go_in,
	input wire logic [7:0] edges_in,
	output logic pin_out,
	output logic busy_out
);
	timeunit 1ns;
	timeprecision 1ns;
	localparam int HOLD = 2;
	logic [7:0] left_q = 8'h00;
	int cnt_q = 0;
	initial pin_out = 1'b0;
	initial busy_out = 1'b0;
	// Each level is held exactly the shortest legal time before the next change.
	always @(posedge clk_in)
	begin
		if (go_in)
		begin
			left_q <= edges_in;
			cnt_q <= 0;
			busy_out <= (edges_in != 8'h00);
		end
		else if (busy_out && cnt_q + 1 >= HOLD)
		begin
			pin_out <= ~pin_out;
			cnt_q <= 0;
			left_q <= left_q - 8'h01;
			busy_out <= (left_q != 8'h01);
		end
		else if (busy_out)
			cnt_q <= cnt_q + 1;
	end
endmodule // tcpm_pin_model

// File: tb/testbench.sv
// Register-level tests of the timer through its bus and capture pin.
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [11:0] addr = 12'h000;
	logic [31:0] wdata = 32'h0000_0000;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [31:0] rdata;
	logic pin;
	logic pwm;
	logic go = 1'b0;
	logic [7:0] n_edge = 8'h00;
	logic busy;
	logic [31:0] v;
	logic [31:0] cap;
	logic [31:0] hi;
	int n_fail = 0;
	int checks = 0;

	// The clock toggles every half period of 5 ns.
	always #5 clk = ~clk;

	tcpm_timer #(.RTC_DIV(4)) u_dut (.clk_in(clk), .rst_n_in(rst_n), .addr_in(addr), .wdata_in(wdata),
		.wr_in(wr), .rd_in(rd), .rdata_out(rdata), .ccp_in(pin), .pwm_out(pwm));
	tcpm_pin_model u_pin (.clk_in(clk), .go_in(go), .edges_in(n_edge), .pin_out(pin), .busy_out(busy));

	task automatic tally_and_finish;
		$display("checks=%0d n_fail=%0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp)
		begin
			n_fail++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// A write is one strobe cycle; the strobe drops at the edge that takes it.
	task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	// Read data are taken in the middle of the one cycle after the strobe.
	task automatic rd_reg(input logic [11:0] a, output logic [31:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		d = rdata;
	endtask

	task automatic rc(input logic [11:0] a, input logic [31:0] exp);
		logic [31:0] d;
		rd_reg(a, d);
		chk(d, exp);
	endtask

	// Asks the pin model for a burst and lets the synchroniser settle after it.
	task automatic edges(input logic [7:0] n);
		@(posedge clk);
		go <= 1'b1;
		n_edge <= n;
		@(posedge clk);
		go <= 1'b0;
		@(posedge clk);
		for (int i = 0; i < 400 && busy === 1'b1; i++)
			@(posedge clk);
		repeat (6) @(posedge clk);
	endtask

	task automatic edge_case(input logic [1:0] ev, input logic [7:0] n, input logic [31:0] ec,
		input logic [31:0] ectl, input logic [31:0] er);
		wr_reg(tcpm_pkg::CTL_OFF, {28'h000_0000, ev, 2'b01});
		edges(n);
		rc(tcpm_pkg::CNT_OFF, ec);
		rc(tcpm_pkg::CTL_OFF, ectl);
		rc(tcpm_pkg::RIS_OFF, er);
		rc(tcpm_pkg::MIS_OFF, er);
		wr_reg(tcpm_pkg::ICR_OFF, 32'h0000_0002);
	endtask

	// Counts high cycles of the PWM output over four periods of 17 cycles.
	task automatic pwm_hi;
		hi = 32'h0000_0000;
		repeat (68)
		begin
			@(negedge clk);
			if (pwm === 1'b1)
				hi = hi + 32'h0000_0001;
		end
	endtask

	// A hung test is cut short well after the expected run time.
	initial
	begin
		repeat (20000) @(posedge clk);
		n_fail++;
		tally_and_finish;
	end

	// Main sequence: reset values, timers, edge count, edge timing, PWM, clock mode.
	initial
	begin
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		rc(tcpm_pkg::ILR_OFF, 32'h0000_FFFF);
		rc(tcpm_pkg::CNT_OFF, 32'h0000_FFFF);
		rc(tcpm_pkg::MATCH_OFF, 32'h0000_FFFF);
		rc(12'h0FC, 32'h0000_0000);
		wr_reg(tcpm_pkg::MODE_OFF, 32'h0000_0002);
		wr_reg(tcpm_pkg::ILR_OFF, 32'h0000_0020);
		wr_reg(tcpm_pkg::IMR_OFF, 32'h0000_0001);
		wr_reg(tcpm_pkg::CTL_OFF, 32'h0000_0001);
		repeat (100) @(posedge clk);
		rc(tcpm_pkg::RIS_OFF, 32'h0000_0001);
		rc(tcpm_pkg::MIS_OFF, 32'h0000_0001);
		rc(tcpm_pkg::CTL_OFF, 32'h0000_0001);
		wr_reg(tcpm_pkg::CTL_OFF, 32'h0000_0000);
		wr_reg(tcpm_pkg::ICR_OFF, 32'h0000_0000);
		rc(tcpm_pkg::RIS_OFF, 32'h0000_0001);
		wr_reg(tcpm_pkg::ICR_OFF, 32'h0000_0001);
		rc(tcpm_pkg::RIS_OFF, 32'h0000_0000);
		wr_reg(tcpm_pkg::CFG_OFF, 32'h0000_0004);
		wr_reg(tcpm_pkg::MODE_OFF, 32'h0000_0001);
		wr_reg(tcpm_pkg::PRE_OFF, 32'h0000_0003);
		wr_reg(tcpm_pkg::ILR_OFF, 32'h0000_0020);
		wr_reg(tcpm_pkg::CTL_OFF, 32'h0000_0001);
		repeat (60) @(posedge clk);
		rc(tcpm_pkg::RIS_OFF, 32'h0000_0000);
		repeat (120) @(posedge clk);
		rc(tcpm_pkg::RIS_OFF, 32'h0000_0001);
		rc(tcpm_pkg::CTL_OFF, 32'h0000_0000);
		wr_reg(tcpm_pkg::ICR_OFF, 32'h0000_000F);
		wr_reg(tcpm_pkg::ILR_OFF, 32'h0000_000A);
		wr_reg(tcpm_pkg::MODE_OFF, 32'h0000_0003);
		wr_reg(tcpm_pkg::MATCH_OFF, 32'h0000_0006);
		wr_reg(tcpm_pkg::IMR_OFF, 32'h0000_0002);
		edge_case(2'h3, 8'h06, 32'h0000_000A, 32'h0000_000C, 32'h0000_0002);
		edge_case(2'h0, 8'h04, 32'h0000_0008, 32'h0000_0001, 32'h0000_0000);
		edge_case(2'h1, 8'h04, 32'h0000_000A, 32'h0000_0004, 32'h0000_0002);
		wr_reg(tcpm_pkg::MODE_OFF, 32'h0000_0007);
		wr_reg(tcpm_pkg::ILR_OFF, 32'h0000_FFFF);
		wr_reg(tcpm_pkg::IMR_OFF, 32'h0000_0004);
		wr_reg(tcpm_pkg::CTL_OFF, 32'h0000_0001);
		edges(8'h01);
		rd_reg(tcpm_pkg::CNT_OFF, cap);
		v = (cap < 32'h0000_FFFF && cap > 32'h0000_FF00) ? 32'h0000_0001 : 32'h0000_0000;
		chk(v, 32'h0000_0001);
		rc(tcpm_pkg::RIS_OFF, 32'h0000_0004);
		wr_reg(tcpm_pkg::ICR_OFF, 32'h0000_0004);
		edges(8'h01);
		rc(tcpm_pkg::RIS_OFF, 32'h0000_0000);
		rc(tcpm_pkg::CNT_OFF, cap);
		wr_reg(tcpm_pkg::CTL_OFF, 32'h0000_000D);
		edges(8'h01);
		rc(tcpm_pkg::RIS_OFF, 32'h0000_0004);
		wr_reg(tcpm_pkg::ICR_OFF, 32'h0000_0004);
		edges(8'h01);
		rc(tcpm_pkg::RIS_OFF, 32'h0000_0000);
		wr_reg(tcpm_pkg::CTL_OFF, 32'h0000_0000);
		wr_reg(tcpm_pkg::MODE_OFF, 32'h0000_000A);
		wr_reg(tcpm_pkg::ILR_OFF, 32'h0000_0010);
		wr_reg(tcpm_pkg::MATCH_OFF, 32'h0000_0008);
		wr_reg(tcpm_pkg::CTL_OFF, 32'h0000_0001);
		repeat (40) @(posedge clk);
		pwm_hi();
		chk(hi, 32'h0000_0020);
		rc(tcpm_pkg::RIS_OFF, 32'h0000_0000);
		wr_reg(tcpm_pkg::CTL_OFF, 32'h0000_0041);
		repeat (10) @(posedge clk);
		pwm_hi();
		chk(hi, 32'h0000_0024);
		wr_reg(tcpm_pkg::CTL_OFF, 32'h0000_0000);
		wr_reg(tcpm_pkg::CFG_OFF, 32'h0000_0001);
		wr_reg(tcpm_pkg::MATCH_OFF, 32'h0000_0002);
		wr_reg(tcpm_pkg::IMR_OFF, 32'h0000_0008);
		wr_reg(tcpm_pkg::CTL_OFF, 32'h0000_0001);
		edges(8'h10);
		rc(tcpm_pkg::RIS_OFF, 32'h0000_0008);
		rc(tcpm_pkg::MIS_OFF, 32'h0000_0008);
		rc(tcpm_pkg::CNT_OFF, 32'h0000_0000);
		edges(8'h08);
		rc(tcpm_pkg::CNT_OFF, 32'h0000_0001);
		tally_and_finish;
	end
endmodule // testbench
